// ### logic/adc_serial_result_shifter.sv
// Purpose: shifts converted results out on one serial line, timed by the host bit clock
// Assumes: the conversion trigger changes only around bit-clock edges (same domain)
// Notes: the bit clock must run during i_reset for the output to go undriven
`timescale 1ns/1ps
module adc_serial_result_shifter #(
    parameter int CHANNELS = adc_shift_pkg::MAX_CHANNELS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_bit_clk,
    input wire logic i_conversion_trigger,
    input wire logic i_bipolar_select,
    input wire logic [CHANNELS*adc_shift_pkg::DATA_BITS-1:0] i_result_data,
    input wire logic i_result_valid,
    output logic o_result_ready,
    output logic o_serial_result_out,
    output logic o_serial_result_oe
);
    localparam int W = adc_shift_pkg::DATA_BITS;
    localparam int FW = CHANNELS * W;
    localparam int CW = adc_shift_pkg::CNT_W;
    localparam logic [CW-1:0] FRAME_SLOTS = CW'(CHANNELS * adc_shift_pkg::SLOT_BITS);
    localparam logic [CW-1:0] CNT_ONE = 7'h01;

    // ************************************************************
    // system clock side
    // ************************************************************

    result_xfer_if #(.WIDTH(FW)) xfer ();

    logic bipolar_sync;
    logic ack_sync;

    bit_sync #(.WIDTH(1)) u_bip_sync (
        .i_clk(i_clk),
        .i_async(i_bipolar_select),
        .o_sync(bipolar_sync)
    );

    bit_sync #(.WIDTH(1)) u_ack_sync (
        .i_clk(i_clk),
        .i_async(xfer.ack),
        .o_sync(ack_sync)
    );

    result_capture #(.CHANNELS(CHANNELS)) u_capture (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_result_data(i_result_data),
        .i_result_valid(i_result_valid),
        .i_bipolar_select(bipolar_sync),
        .i_ack_sync(ack_sync),
        .o_result_ready(o_result_ready),
        .xfer(xfer)
    );

    // ************************************************************
    // bit clock side
    // ************************************************************

    logic link_rst;
    logic req_sync;

    bit_sync #(.WIDTH(1)) u_rst_sync (
        .i_clk(i_bit_clk),
        .i_async(i_reset),
        .o_sync(link_rst)
    );

    bit_sync #(.WIDTH(1)) u_req_sync (
        .i_clk(i_bit_clk),
        .i_async(xfer.req),
        .o_sync(req_sync)
    );

    logic ack_q;
    logic [FW-1:0] hold_q;
    logic [FW-1:0] frame_q;
    logic conversion_trigger_q;
    logic [CW-1:0] cnt_q;
    logic sdo_q;
    logic oe_q;

    logic start;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] slot;
    logic in_frame;
    logic [3:0] pos;
    logic [2:0] word;

    // bit of the frame register sent at a given slot, msb of each word first
    function automatic int bit_index(input logic [2:0] w, input logic [3:0] p);
        int idx;
        idx = int'(w) * W + (W - 1) - int'(p);
        return idx;
    endfunction

    // newest snapshot taken whenever one arrives
    always_ff @(posedge i_bit_clk) begin
        if (link_rst) begin
            ack_q <= 1'h0;
        end else begin
            ack_q <= req_sync;
        end
    end

    always_ff @(posedge i_bit_clk) begin
        if (link_rst) begin
            hold_q <= '0;
        end else if (req_sync != ack_q) begin
            hold_q <= xfer.data;
        end
    end

    assign xfer.ack = ack_q;

    always_ff @(posedge i_bit_clk) begin
        if (link_rst) begin
            conversion_trigger_q <= 1'h0;
        end else begin
            conversion_trigger_q <= i_conversion_trigger;
        end
    end

    // rising trigger accepted only outside lockout
    assign start = i_conversion_trigger && !conversion_trigger_q && (cnt_q >= adc_shift_pkg::LOCKOUT_EDGES);

    always_comb begin
        if (start) begin
            cnt_d = '0;
        end else if (cnt_q == adc_shift_pkg::CNT_IDLE) begin
            cnt_d = adc_shift_pkg::CNT_IDLE;
        end else begin
            cnt_d = cnt_q + CNT_ONE;
        end
    end

    // edges since the accepted trigger, saturating at idle
    always_ff @(posedge i_bit_clk) begin
        if (link_rst) begin
            cnt_q <= adc_shift_pkg::CNT_IDLE;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // frame snapshot frozen for the whole frame
    always_ff @(posedge i_bit_clk) begin
        if (link_rst) begin
            frame_q <= '0;
        end else if (start) begin
            frame_q <= hold_q;
        end
    end

    // slots counted from the third edge
    assign slot = cnt_d - adc_shift_pkg::FIRST_EDGE;
    assign in_frame = (cnt_d >= adc_shift_pkg::FIRST_EDGE) && (slot < FRAME_SLOTS);
    assign pos = slot[3:0];
    assign word = slot[6:4];

    // undriven at reset and between frames
    always_ff @(posedge i_bit_clk) begin
        if (link_rst) begin
            oe_q <= adc_shift_pkg::OE_RESET;
        end else begin
            // twelve data and two filler slots driven
            oe_q <= in_frame && (pos < adc_shift_pkg::DRIVEN_SLOTS);
        end
    end

    // launched on the rising edge, held a full period
    always_ff @(posedge i_bit_clk) begin
        if (link_rst) begin
            sdo_q <= adc_shift_pkg::SDO_RESET;
        end else if (in_frame && (pos < adc_shift_pkg::DATA_SLOTS)) begin
            sdo_q <= frame_q[bit_index(word, pos)];
        end else begin
            sdo_q <= 1'h0;
        end
    end

    assign o_serial_result_out = sdo_q;
    assign o_serial_result_oe = oe_q;

    // ************************************************************
    // checks
    // ************************************************************

    logic [CW-1:0] oe_cnt_q;

    always_ff @(posedge i_bit_clk) begin
        if (link_rst || start) begin
            oe_cnt_q <= '0;
        end else if (oe_q) begin
            oe_cnt_q <= oe_cnt_q + CNT_ONE;
        end
    end

    property p_reset_hiz;
        @(posedge i_bit_clk)
        link_rst |=> !oe_q;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz)
        else $error("output driven right after reset");

    property p_idle_hiz;
        @(posedge i_bit_clk) disable iff (link_rst)
        (cnt_q == adc_shift_pkg::CNT_IDLE && !start) |=> !oe_q;
    endproperty
    a_idle_hiz: assert property (p_idle_hiz)
        else $error("output driven with no conversion started");

    property p_first_bit;
        @(posedge i_bit_clk) disable iff (link_rst)
        start |-> ##1 !oe_q ##1 !oe_q ##1 !oe_q ##1 oe_q;
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first bit not driven after third edge");

    property p_word_gap;
        @(posedge i_bit_clk) disable iff (link_rst)
        $fell(oe_q) |-> (!$past(sdo_q) && !$past(sdo_q, 2)) ##1 !oe_q;
    endproperty
    a_word_gap: assert property (p_word_gap)
        else $error("word not followed by two filler and two idle slots");

    property p_frame_len;
        @(posedge i_bit_clk) disable iff (link_rst)
        (cnt_q == adc_shift_pkg::LOCKOUT_EDGES + 7'h03) |->
            (oe_cnt_q == CW'(CHANNELS * 14));
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("driven slot count per frame is wrong");

    property p_lockout;
        @(posedge i_bit_clk) disable iff (link_rst)
        (i_conversion_trigger && !conversion_trigger_q && cnt_q < adc_shift_pkg::LOCKOUT_EDGES)
            |=> (cnt_q == $past(cnt_q) + CNT_ONE);
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("trigger accepted during lockout");

    property p_msb_first;
        @(posedge i_bit_clk) disable iff (link_rst)
        start |-> ##4 (sdo_q == $past(hold_q[W-1], 4));
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first bit of frame is not the msb of word 0");

    property p_bit_hold;
        @(posedge i_bit_clk) disable iff (link_rst)
        (oe_q && $past(oe_q)) |-> (sdo_q == $past(frame_q[bit_index(word, pos)]))
            || !$past(in_frame) || ($past(pos) >= adc_shift_pkg::DATA_SLOTS);
    endproperty
    a_bit_hold: assert property (p_bit_hold)
        else $error("driven bit does not match frame data");

    property p_filler_low;
        @(posedge i_bit_clk) disable iff (link_rst)
        (in_frame && pos >= adc_shift_pkg::DATA_SLOTS && pos < adc_shift_pkg::DRIVEN_SLOTS)
            |=> (oe_q && !sdo_q);
    endproperty
    a_filler_low: assert property (p_filler_low)
        else $error("filler slot not driven low");

    property p_gap_hiz;
        @(posedge i_bit_clk) disable iff (link_rst)
        (in_frame && pos >= adc_shift_pkg::DRIVEN_SLOTS) |=> !oe_q;
    endproperty
    a_gap_hiz: assert property (p_gap_hiz)
        else $error("gap slot driven");

    property p_quiet_line;
        @(posedge i_bit_clk) disable iff (link_rst)
        !oe_q |-> !sdo_q;
    endproperty
    a_quiet_line: assert property (p_quiet_line)
        else $error("data bit left high while undriven");

    property p_trigger_start;
        @(posedge i_bit_clk) disable iff (link_rst)
        (i_conversion_trigger && !conversion_trigger_q && cnt_q >= adc_shift_pkg::LOCKOUT_EDGES)
            |=> (cnt_q == 7'h00);
    endproperty
    a_trigger_start: assert property (p_trigger_start)
        else $error("rising trigger outside lockout did not start a frame");

    property p_frame_stable;
        @(posedge i_bit_clk) disable iff (link_rst)
        !start |=> $stable(frame_q);
    endproperty
    a_frame_stable: assert property (p_frame_stable)
        else $error("frame snapshot changed inside a frame");

    property p_rise_slot;
        @(posedge i_bit_clk) disable iff (link_rst)
        $rose(oe_q) |-> ($past(pos) == 4'h0);
    endproperty
    a_rise_slot: assert property (p_rise_slot)
        else $error("output driven from a slot other than a word start");

    property p_ready_drop;
        @(posedge i_clk) disable iff (i_reset)
        (i_result_valid && o_result_ready) |=> !o_result_ready;
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready stayed high with a snapshot in flight");
endmodule

// ### logic/adc_shift_pkg.sv
// Purpose: shared constants for the serial result shifter
// Assumes: 12-bit results, up to six channels, 16 bit periods per channel
// Notes: counts are in rising edges of the link bit clock
//
// Overview of operation
// - after reset the serial result output is not driven (high impedance).
// - the output stays undriven until a rising conversion trigger starts a frame.
// - from the third rising bit-clock edge after the trigger, up to six 12-bit words go out.
// - each word is followed by two don't-care bits, then two undriven bit periods.
// - each bit is launched on a rising bit-clock edge and is valid by the next rising edge.
// - a frame spans 16 bit periods per channel, 16 to 96 in all; the host supplies the clocks.
// - a rising trigger starts a frame; further triggers are ignored until 96 edges have passed.
// - each result word is sent most significant bit first.
// - results are straight binary with bipolar select low, two's complement with it high.
package adc_shift_pkg;
    localparam int DATA_BITS = 12;
    localparam int SLOT_BITS = 16;
    localparam int MAX_CHANNELS = 6;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] FIRST_EDGE = 7'h03;
    localparam logic [CNT_W-1:0] LOCKOUT_EDGES = 7'h60;
    localparam logic [CNT_W-1:0] CNT_IDLE = 7'h7f;
    localparam logic [3:0] DATA_SLOTS = 4'hc;
    localparam logic [3:0] DRIVEN_SLOTS = 4'he;
    localparam logic OE_RESET = 1'h0;
    localparam logic SDO_RESET = 1'h0;
endpackage

// ### logic/bit_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input is a level that holds for several destination cycles
// Notes: no reset, so it can also carry a reset, but only while the destination clock runs
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_clk) begin
        meta_q <= i_async;
        sync_q <= meta_q;
    end

    assign o_sync = sync_q;
endmodule

// ### logic/result_capture.sv
// Purpose: formats and publishes result snapshots toward the link domain
// Assumes: i_bipolar_select and i_ack_sync are already synchronised
// Notes: one snapshot in flight; ready drops until the link acknowledges
`timescale 1ns/1ps
module result_capture #(
    parameter int CHANNELS = adc_shift_pkg::MAX_CHANNELS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [CHANNELS*adc_shift_pkg::DATA_BITS-1:0] i_result_data,
    input wire logic i_result_valid,
    input wire logic i_bipolar_select,
    input wire logic i_ack_sync,
    output logic o_result_ready,
    result_xfer_if.src xfer
);
    localparam int W = adc_shift_pkg::DATA_BITS;

    logic req_q;
    logic [CHANNELS*W-1:0] data_q;
    logic [CHANNELS*W-1:0] coded;

    for (genvar c = 0; c < CHANNELS; c++) begin : g_code
        assign coded[c*W +: W] = {i_result_data[c*W+W-1] ^ i_bipolar_select,
                                  i_result_data[c*W +: W-1]};
    end

    assign o_result_ready = (req_q == i_ack_sync);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            req_q <= 1'h0;
        end else if (i_result_valid && o_result_ready) begin
            req_q <= ~req_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            data_q <= '0;
        end else if (i_result_valid && o_result_ready) begin
            data_q <= coded;
        end
    end

    assign xfer.req = req_q;
    assign xfer.data = data_q;

    property p_code_format;
        @(posedge i_clk) disable iff (i_reset)
        (i_result_valid && o_result_ready) |=>
            (data_q[W-1] == ($past(i_result_data[W-1]) ^ $past(i_bipolar_select)))
            && (data_q[W-2:0] == $past(i_result_data[W-2:0]));
    endproperty
    a_code_format: assert property (p_code_format)
        else $error("result coding does not follow bipolar select");
endmodule

// ### logic/result_xfer_if.sv
// Purpose: carries one result snapshot from the system clock to the bit clock
// Assumes: toggle request with toggle acknowledge; data held while pending
// Notes: no clock of its own; each side synchronises the other's toggle
`timescale 1ns/1ps
interface result_xfer_if #(
    parameter int WIDTH = 72
) ();
    logic req;
    logic ack;
    logic [WIDTH-1:0] data;

    modport src (
        output req,
        output data,
        input ack
    );

    modport dst (
        input req,
        input data,
        output ack
    );
endinterface

// ### verification/host_port_model.sv
// Purpose: host serial port model: bit clock, frame trigger, falling-edge capture
// Assumes: bit clock runs only while i_run is high and stops low
// Notes: capture index counts rising edges from the trigger rise
`timescale 1ns/1ps
module host_port_model (
    input wire logic i_run,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_bit_clk,
    output logic o_trigger
);
    int edge_n = 200;
    logic restart = 1'h0;
    logic cap_d [0:127];
    logic cap_e [0:127];

    // ****************
    // bit clock
    // ****************
    // external positive clock
    initial begin
        o_bit_clk = 1'h0;
        o_trigger = 1'h0;
        #1.3;
        forever begin
            #3;
            if (i_run || o_bit_clk) begin
                o_bit_clk = ~o_bit_clk;
            end
        end
    end

    // ****************
    // frame trigger and capture
    // ****************
    // positive frame pulse
    task automatic send_trigger(input int width, input logic rearm);
        @(posedge o_bit_clk);
        o_trigger <= 1'h1;
        restart <= rearm;
        repeat (width) @(posedge o_bit_clk);
        o_trigger <= 1'h0;
    endtask

    always @(posedge o_bit_clk) begin
        if (restart && o_trigger) begin
            edge_n <= 0;
            restart <= 1'h0;
        end else if (edge_n < 200) begin
            edge_n <= edge_n + 1;
        end
    end

    always @(negedge o_bit_clk) begin
        if (edge_n < 128) begin
            cap_d[edge_n] <= i_sdo;
            cap_e[edge_n] <= i_sdo_oe;
        end
    end
endmodule

// ### verification/tb_top.sv
// Purpose: self-checking bench for the serial result shifter
// Assumes: host model supplies the bit clock and trigger
// Notes: released line shows the inverse of the last output bit
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic run = 1'h1;
    logic bipolar = 1'h0;
    logic [71:0] data = 72'h0;
    logic valid = 1'h0;
    logic ready;
    logic serial_result_out;
    logic sdo_oe;
    logic sdo_line;
    logic bit_clk;
    logic trigger;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;
    assign sdo_line = sdo_oe ? serial_result_out : ~serial_result_out;

    adc_serial_result_shifter i_dut (
        .i_clk(clk),
        .i_reset(reset),
        .i_bit_clk(bit_clk),
        .i_conversion_trigger(trigger),
        .i_bipolar_select(bipolar),
        .i_result_data(data),
        .i_result_valid(valid),
        .o_result_ready(ready),
        .o_serial_result_out(serial_result_out),
        .o_serial_result_oe(sdo_oe)
    );

    host_port_model i_host (
        .i_run(run),
        .i_sdo(sdo_line),
        .i_sdo_oe(sdo_oe),
        .o_bit_clk(bit_clk),
        .o_trigger(trigger)
    );

    // ****************
    // shared tasks
    // ****************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic load(input logic [71:0] d, input logic bipolar_select);
        int n;
        @(posedge clk);
        run <= 1'h1;
        bipolar <= bipolar_select;
        repeat (4) @(posedge clk);
        data <= d;
        valid <= 1'h1;
        @(posedge clk);
        valid <= 1'h0;
        n = 0;
        @(posedge clk);
        chk("ready_busy", ready, 1'h0);
        while (ready !== 1'h1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("ready", ready, 1'h1);
    endtask

    // ****************
    // frame scenario
    // ****************
    task automatic frame(input logic [71:0] d, input logic bipolar_select, input logic retrig);
        logic [11:0] w;
        int s;
        int n;
        logic ee;
        logic ed;
        @(posedge clk);
        run <= 1'h1;
        i_host.send_trigger(2, 1'h1);
        if (retrig) begin
            repeat (30) @(posedge bit_clk);
            i_host.send_trigger(2, 1'h0);
        end
        n = 0;
        while (i_host.edge_n < 101 && n < 300) begin
            @(posedge bit_clk);
            n++;
        end
        @(posedge clk);
        run <= 1'h0;
        for (int e = 0; e < 101; e++) begin
            s = e - 3;
            ee = 1'h0;
            ed = 1'h0;
            if (e >= 3 && s < 96) begin
                w = d[12*(s/16) +: 12];
                if (bipolar_select) begin
                    w[11] = ~w[11];
                end
                ee = (s % 16) < 14;
                ed = (s % 16) < 12 ? w[11-(s%16)] : 1'h0;
            end
            chk("oe", i_host.cap_e[e], ee);
            if (ee) begin
                chk("bit", i_host.cap_d[e], ed);
            end
        end
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        for (int k = 0; k < 20; k++) begin
            @(posedge bit_clk);
            chk("oe_idle", sdo_oe, 1'h0);
        end
        chk("ready_reset", ready, 1'h1);
        load(72'hfedcba9876543210a5, 1'h0);
        frame(72'hfedcba9876543210a5, 1'h0, 1'h0);
        load(72'h8007ff000fff123abc, 1'h1);
        frame(72'h8007ff000fff123abc, 1'h1, 1'h1);
        frame(72'h8007ff000fff123abc, 1'h1, 1'h0);
        tally_and_finish();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
endmodule
